// file: hdl/dsmdc_ctl.sv
// Functional notes
// - Eight row strobes, decoded from bank bits
// - Bank bits flow, held at data latch
// - Bank index is binary of bank bits
// - Unselected banks receive no strobe
// - Refresh: decoder off, all strobes on tap3
// - Seven array lines, row/column from host
// - Row address passes while taps idle
// - Address latch captures row and column
// - Column switch rise selects latched column
// - Column removed at cycle start end
// - Refresh drives counter during cycle start
// - Reads deassert both byte write enables
// - Word write asserts both enables
// - Byte write picks byte by address bit0
// - Enables from bus, inactive in refresh
// - Enables and direction held at data latch
// - Array words eighteen bits, parity high
// - Seven data path outputs, four distinct modes
// - Refresh indicators only in refresh
// - Register cycles act on master sync rise
// - Read: permit enables latch, switch-fall acks
// - Write acknowledge on first tap rise
// - Outputs hold until master sync falls
// - Register read picks group by reg_ext_sel
`include "dsmdc_regs.svh"
`default_nettype none
module dsmdc_ctl
    import dsmdc_pkg::*;
#(
    parameter int MUX_BITS = `DSMDC_MUX_BITS
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic bank_sel_hi,
    input wire logic bank_sel_mid,
    input wire logic bank_sel_lo,
    input wire logic [14:0] host_addr,
    input wire logic [6:0] refresh_addr,
    input wire logic bus_c1,
    input wire logic bus_c0,
    input wire logic refresh,
    input wire logic addr_latch_strobe,
    input wire logic data_in_latch_strobe,
    input wire logic cycle_start_tap,
    input wire logic column_switch_tap,
    input wire logic first_timing_tap,
    input wire logic third_timing_tap,
    input wire logic sixth_timing_tap,
    input wire logic array_out_permit,
    input wire logic reg_select,
    input wire logic master_sync_int,
    input wire logic reg_ext_sel,
    output logic [7:0] row_strobe,
    output logic [MUX_BITS-1:0] array_addr,
    output logic [1:0] byte_write_en,
    output logic write_dir_flag,
    output logic refresh_ind,
    output logic array_out_latch_en,
    output logic out_en,
    output logic slave_ack_int,
    output logic reg_common_out_en,
    output logic reg_data_out_en,
    output logic ext_err_addr_out_en,
    output logic reg_write_clock
);
    ////////////////////////////////////////////////////////////////////////
    // Tap sampling and edge pulses
    logic cs_d_r, sw_d_r, t1_d_r, perm_d_r, ms_d_r, al_d_r, di_d_r;
    logic cs_fall, sw_rise, sw_fall, t1_rise, perm_rise, ms_rise, ms_fall;
    logic al_rise, di_rise;

    // One register per edge-detected tap (tap3 and tap6 have none) so every edge is a single-cycle pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cs_d_r <= 1'b0;
            sw_d_r <= 1'b0;
            t1_d_r <= 1'b0;
            perm_d_r <= 1'b0;
            ms_d_r <= 1'b0;
            al_d_r <= 1'b0;
            di_d_r <= 1'b0;
        end else begin
            cs_d_r <= cycle_start_tap;
            sw_d_r <= column_switch_tap;
            t1_d_r <= first_timing_tap;
            perm_d_r <= array_out_permit;
            ms_d_r <= master_sync_int;
            al_d_r <= addr_latch_strobe;
            di_d_r <= data_in_latch_strobe;
        end
    end

    // Shared edge helpers, so every tap edge is judged the same way
    function automatic logic dsmdc_rise(input logic prev, input logic cur);
        dsmdc_rise = ~prev & cur;
    endfunction

    function automatic logic dsmdc_fall(input logic prev, input logic cur);
        dsmdc_fall = prev & ~cur;
    endfunction

    // A pulse is high only in the first cycle after its tap changes;
    // a tap shorter than one clock is lost, so the chain must hold each tap a cycle
    assign cs_fall = dsmdc_fall(cs_d_r, cycle_start_tap);
    assign sw_rise = dsmdc_rise(sw_d_r, column_switch_tap);
    assign sw_fall = dsmdc_fall(sw_d_r, column_switch_tap);
    assign t1_rise = dsmdc_rise(t1_d_r, first_timing_tap);
    assign perm_rise = dsmdc_rise(perm_d_r, array_out_permit);
    assign ms_rise = dsmdc_rise(ms_d_r, master_sync_int);
    assign ms_fall = dsmdc_fall(ms_d_r, master_sync_int);
    assign al_rise = dsmdc_rise(al_d_r, addr_latch_strobe);
    assign di_rise = dsmdc_rise(di_d_r, data_in_latch_strobe);

    ////////////////////////////////////////////////////////////////////////
    // Row strobe generation
    logic addr_held_r, data_held_r;

    // Latch phases last until the cycle start tap ends
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            addr_held_r <= 1'b0;
            data_held_r <= 1'b0;
        end else begin
            if (al_rise) begin
                addr_held_r <= 1'b1;
            end else if (cs_fall) begin
                addr_held_r <= 1'b0;
            end
            if (di_rise) begin
                data_held_r <= 1'b1;
            end else if (cs_fall) begin
                data_held_r <= 1'b0;
            end
        end
    end

    dsmdc_ras_gen u_ras (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .bank_sel({bank_sel_hi, bank_sel_mid, bank_sel_lo}),
        .bank_hold(data_held_r | di_rise),
        .addr_latched(addr_latch_strobe | addr_held_r),
        .refresh(refresh),
        .ref_all_on(third_timing_tap),
        .row_strobe(row_strobe)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address multiplexer
    logic [6:0] row_r, col_r;
    dsmdc_src_t src_r, src_nxt;

    // Capture both halves on the latch strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            row_r <= `DSMDC_MUX_RST;
            col_r <= `DSMDC_MUX_RST;
        end else if (al_rise) begin
            row_r <= host_addr[`DSMDC_ROW_LSB +: 7];
            col_r <= host_addr[`DSMDC_COL_LSB +: 7];
        end
    end

    // Source selection; refresh overrides host sources entirely
    always_comb begin
        src_nxt = src_r;
        if (refresh) begin
            src_nxt = cycle_start_tap ? DSMDC_SRC_REF : DSMDC_SRC_NONE;
        end else begin
            case (src_r)
                DSMDC_SRC_NONE: begin
                    if (!cycle_start_tap && !column_switch_tap) begin
                        src_nxt = DSMDC_SRC_ROW;
                    end
                end
                DSMDC_SRC_ROW: begin
                    if (sw_rise) begin
                        src_nxt = DSMDC_SRC_COL;
                    end
                end
                DSMDC_SRC_COL: begin
                    if (cs_fall) begin
                        src_nxt = DSMDC_SRC_NONE;
                    end
                end
                DSMDC_SRC_REF: src_nxt = DSMDC_SRC_NONE;
                default: src_nxt = DSMDC_SRC_NONE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            src_r <= DSMDC_SRC_NONE;
        end else begin
            src_r <= src_nxt;
        end
    end

    // Row path is live until latched, so a late row address still reaches the array
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            array_addr <= `DSMDC_MUX_RST;
        end else begin
            case (src_nxt)
                DSMDC_SRC_ROW: array_addr <= addr_held_r ? row_r : host_addr[`DSMDC_ROW_LSB +: 7];
                DSMDC_SRC_COL: array_addr <= col_r;
                DSMDC_SRC_REF: array_addr <= refresh_addr;
                default: array_addr <= `DSMDC_MUX_RST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte write enables; array word is data 15-00 plus parity 17,16
    function automatic logic [1:0] dsmdc_wr_decode(input logic c1, input logic c0, input logic a0);
        if (c1) begin
            dsmdc_wr_decode = 2'h0;
        end else if (c0) begin
            dsmdc_wr_decode = 2'h3;
        end else begin
            dsmdc_wr_decode = a0 ? 2'h2 : 2'h1;
        end
    endfunction

    // Follow the bus until the data-in latch, then hold for the cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            byte_write_en <= 2'h0;
            write_dir_flag <= 1'b0;
        end else if (refresh) begin
            byte_write_en <= 2'h0;
        end else if (!data_held_r) begin
            byte_write_en <= dsmdc_wr_decode(bus_c1, bus_c0, host_addr[0]);
            write_dir_flag <= ~bus_c1;
        end
    end

    // Refresh indicator mirrors the refresh phase only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            refresh_ind <= 1'b0;
        end else begin
            refresh_ind <= refresh;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data path control outputs
    logic mem_rd, mem_wr, reg_rd, reg_wr;
    logic seq_ok;

    // Taps are ignored in refresh; register access still works
    assign seq_ok = ~refresh & ~reg_select & master_sync_int;
    assign mem_rd = seq_ok & ~write_dir_flag;
    assign mem_wr = seq_ok & write_dir_flag;
    assign reg_rd = reg_select & ms_rise & bus_c1;
    assign reg_wr = reg_select & ms_rise & ~bus_c1;

    // Each output is set by its event and cleared by master sync falling
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            array_out_latch_en <= 1'b0;
            out_en <= 1'b0;
            slave_ack_int <= 1'b0;
            reg_common_out_en <= 1'b0;
            reg_data_out_en <= 1'b0;
            ext_err_addr_out_en <= 1'b0;
            reg_write_clock <= 1'b0;
        end else if (ms_fall || !master_sync_int) begin
            array_out_latch_en <= 1'b0;
            out_en <= 1'b0;
            slave_ack_int <= 1'b0;
            reg_common_out_en <= 1'b0;
            reg_data_out_en <= 1'b0;
            ext_err_addr_out_en <= 1'b0;
            reg_write_clock <= 1'b0;
        end else begin
            if (mem_rd && perm_rise) begin
                array_out_latch_en <= 1'b1;
            end
            if (mem_rd && sw_fall && sixth_timing_tap) begin
                out_en <= 1'b1;
                slave_ack_int <= 1'b1;
            end
            if (mem_wr && t1_rise) begin
                slave_ack_int <= 1'b1;
            end
            if (reg_rd) begin
                out_en <= 1'b1;
                slave_ack_int <= 1'b1;
                reg_common_out_en <= 1'b1;
                reg_data_out_en <= ~reg_ext_sel;
                ext_err_addr_out_en <= reg_ext_sel;
            end
            if (reg_wr) begin
                reg_write_clock <= 1'b1;
                slave_ack_int <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: common/dsmdc_regs.svh
`ifndef DSMDC_REGS_SVH
`define DSMDC_REGS_SVH
// Array geometry
`define DSMDC_BANKS 8
`define DSMDC_BANK_BITS 3
`define DSMDC_MUX_BITS 7
`define DSMDC_WORD_BITS 18
// Host address field positions
`define DSMDC_ROW_LSB 1
`define DSMDC_COL_LSB 8
// Register read group select bit
`define DSMDC_EXT_SEL_BIT 14
// Reset values
`define DSMDC_MUX_RST 7'h00
`define DSMDC_RAS_RST 8'h00
`define DSMDC_RAS_ALL 8'hff
`endif

// file: common/dsmdc_pkg.sv
`default_nettype none
package dsmdc_pkg;
    // Address multiplexer source
    typedef enum logic [3:0] {
        DSMDC_SRC_NONE = 4'b0001,
        DSMDC_SRC_ROW = 4'b0010,
        DSMDC_SRC_COL = 4'b0100,
        DSMDC_SRC_REF = 4'b1000
    } dsmdc_src_t;
endpackage
`default_nettype wire

// file: hdl/dsmdc_ras_gen.sv
`include "dsmdc_regs.svh"
`default_nettype none
module dsmdc_ras_gen
    import dsmdc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [2:0] bank_sel,
    input wire logic bank_hold,
    input wire logic addr_latched,
    input wire logic refresh,
    input wire logic ref_all_on,
    output logic [7:0] row_strobe
);
    logic [2:0] bank_r;
    logic [7:0] row_strobe_nxt;

    // Bank bits flow through until the data-in latch, then stay put
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bank_r <= 3'h0;
        end else if (!bank_hold) begin
            bank_r <= bank_sel;
        end
    end

    // Decoder is gated by the address latch and disabled in refresh
    always_comb begin
        row_strobe_nxt = `DSMDC_RAS_RST;
        if (refresh) begin
            if (ref_all_on) begin
                row_strobe_nxt = `DSMDC_RAS_ALL;
            end
        end else if (addr_latched) begin
            row_strobe_nxt[bank_r] = 1'b1;
        end
    end

    // Registered strobes avoid decoder glitches on the array
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            row_strobe <= `DSMDC_RAS_RST;
        end else begin
            row_strobe <= row_strobe_nxt;
        end
    end
endmodule
`default_nettype wire

// file: sim/dsmdc_ctl_properties.sv
`default_nettype none
module dsmdc_ctl_properties
    import dsmdc_pkg::*;
#(
    parameter int MUX_BITS = 7
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic bank_sel_hi,
    input wire logic bank_sel_mid,
    input wire logic bank_sel_lo,
    input wire logic [14:0] host_addr,
    input wire logic [6:0] refresh_addr,
    input wire logic bus_c1,
    input wire logic bus_c0,
    input wire logic refresh,
    input wire logic addr_latch_strobe,
    input wire logic data_in_latch_strobe,
    input wire logic cycle_start_tap,
    input wire logic column_switch_tap,
    input wire logic first_timing_tap,
    input wire logic third_timing_tap,
    input wire logic reg_select,
    input wire logic master_sync_int,
    input wire logic [7:0] row_strobe,
    input wire logic [MUX_BITS-1:0] array_addr,
    input wire logic [1:0] byte_write_en,
    input wire logic write_dir_flag,
    input wire logic out_en,
    input wire logic slave_ack_int
);
    logic [6:0] col_r;
    logic [1:0] bwe_exp;
    logic [2:0] bank_idx;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // Column copy taken at latch time, so later address churn is ignored
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) col_r <= 7'h00;
        else if ($rose(addr_latch_strobe)) col_r <= host_addr[14:8];
    end
    // Expected byte enables straight from the bus lines
    assign bwe_exp = bus_c1 ? 2'h0 : (bus_c0 ? 2'h3 : (host_addr[0] ? 2'h2 : 2'h1));
    // Bank index as one signal so its history can be sampled
    assign bank_idx = {bank_sel_hi, bank_sel_mid, bank_sel_lo};
    ////////////////////////////////////////////////////////////////////////////
    chk_refresh_all: assert property (refresh && third_timing_tap ##1 refresh && third_timing_tap
        |-> row_strobe == 8'hff) else $error("row strobes not all on");
    chk_refresh_addr: assert property (refresh && cycle_start_tap ##1 refresh && cycle_start_tap
        |-> array_addr == $past(refresh_addr)) else $error("refresh address missing");
    chk_bank_decode: assert property ($rose(addr_latch_strobe) && !refresh
        |-> ##2 row_strobe == (8'h01 << $past(bank_idx, 2)))
        else $error("bank strobe wrong");
    chk_byte_enables: assert property ($rose(data_in_latch_strobe) && !refresh
        |-> ##2 byte_write_en == $past(bwe_exp, 2) && write_dir_flag == !$past(bus_c1, 2))
        else $error("byte enables wrong");
    chk_column_out: assert property ($rose(column_switch_tap) && !refresh
        |-> ##[1:2] array_addr == col_r) else $error("column address missing");
    chk_write_ack: assert property ($rose(first_timing_tap) && master_sync_int && !reg_select
        && !bus_c1 && !refresh |-> ##[1:2] slave_ack_int) else $error("write ack missing");
    chk_reg_read: assert property ($rose(master_sync_int) && reg_select && bus_c1
        |-> ##[1:2] slave_ack_int && out_en) else $error("register read ack missing");
    chk_ack_release: assert property ($fell(master_sync_int)
        |-> ##[1:2] !slave_ack_int && !out_en) else $error("ack not released");
endmodule
bind dsmdc_ctl dsmdc_ctl_properties #(.MUX_BITS(MUX_BITS)) i_dsmdc_ctl_properties (.sys_clk, .rstn,
    .bank_sel_hi, .bank_sel_mid, .bank_sel_lo, .host_addr, .refresh_addr, .bus_c1, .bus_c0, .refresh,
    .addr_latch_strobe, .data_in_latch_strobe, .cycle_start_tap, .column_switch_tap, .first_timing_tap,
    .third_timing_tap, .reg_select, .master_sync_int, .row_strobe, .array_addr, .byte_write_en,
    .write_dir_flag, .out_en, .slave_ack_int);
`default_nettype wire

// file: sim/dsmdc_host_model.sv
`default_nettype none
module dsmdc_host_model (
    input wire logic sys_clk,
    input wire logic slave_ack_int,
    output logic master_sync_int,
    output logic reg_select,
    output logic bus_c1,
    output logic bus_c0,
    output logic [14:0] host_addr,
    output logic [2:0] bank
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus at time zero
    initial begin
        {master_sync_int, reg_select, bus_c1, bus_c0} = 4'h3;
        host_addr = 15'h0000;
        bank = 3'h0;
    end
    // Address and control settle together with the request
    task req(input logic c1, input logic c0, input logic sel, input logic [14:0] a, input logic [2:0] b);
        @(negedge sys_clk);
        {bus_c1, bus_c0, reg_select, host_addr, bank} = {c1, c0, sel, a, b};
        master_sync_int = 1'h1;
    endtask
    // Bounded wait, acknowledge taken at the rising edge
    task wack(output logic ok);
        ok = 1'h0;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge sys_clk);
            ok = slave_ack_int;
        end
        #1;
    endtask
    // Released lines flip so a stale value cannot pass
    task drop();
        @(negedge sys_clk);
        master_sync_int = 1'h0;
        host_addr = ~host_addr;
        {bus_c1, bus_c0, reg_select} = ~{bus_c1, bus_c0, reg_select};
        bank = ~bank;
    endtask
endmodule
`default_nettype wire

// file: sim/dsmdc_ctl_tb.sv
`default_nettype none
module dsmdc_ctl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rstn, rf, ext, master_sync_int, reg_select, bus_c1, bus_c0, write_dir_flag, refresh_ind;
    logic array_out_latch_en, out_en, slave_ack_int, reg_common_out_en, reg_data_out_en, ext_err_addr_out_en;
    logic reg_write_clock, ok;
    logic [7:0] tp, row_strobe;
    logic [6:0] ra, array_addr;
    logic [14:0] host_addr, a;
    logic [4:0] g;
    logic [2:0] bank;
    logic [1:0] byte_write_en, e;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int k;
    // Tap bits: cycle start, addr latch, data latch, column, tap1, tap3, tap6, permit
    dsmdc_ctl i_dsmdc_ctl (.sys_clk, .rstn, .bank_sel_hi(bank[2]), .bank_sel_mid(bank[1]),
        .bank_sel_lo(bank[0]), .host_addr, .refresh_addr(ra), .bus_c1, .bus_c0, .refresh(rf),
        .addr_latch_strobe(tp[6]), .data_in_latch_strobe(tp[5]), .cycle_start_tap(tp[7]),
        .column_switch_tap(tp[4]), .first_timing_tap(tp[3]), .third_timing_tap(tp[2]),
        .sixth_timing_tap(tp[1]), .array_out_permit(tp[0]), .reg_select, .master_sync_int,
        .reg_ext_sel(ext), .row_strobe, .array_addr, .byte_write_en, .write_dir_flag, .refresh_ind,
        .array_out_latch_en, .out_en, .slave_ack_int, .reg_common_out_en, .reg_data_out_en,
        .ext_err_addr_out_en, .reg_write_clock);
    dsmdc_host_model i_dsmdc_host_model (.sys_clk, .slave_ack_int, .master_sync_int, .reg_select,
        .bus_c1, .bus_c0, .host_addr, .bank);
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task print_verdict();
        $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // A hung handshake ends the run as a mismatch
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            print_verdict();
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Two edges per step so registered outputs have landed
    task step(input logic [7:0] v);
        @(negedge sys_clk);
        tp = v;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task mem(input logic c1, input logic c0, input logic [2:0] b);
        e = c1 ? 2'h0 : (c0 ? 2'h3 : (a[0] ? 2'h2 : 2'h1));
        i_dsmdc_host_model.req(c1, c0, 1'h0, a, b);
        step(8'h00);
        chk(array_addr, a[7:1]);
        step(8'hc0);
        chk(row_strobe, 8'h01 << b);
        step(8'he8);
        // Writes drop the request early, so later checks see a flipped bus
        if (!c1) begin
            i_dsmdc_host_model.wack(ok);
            chk(ok, 1'h1);
            i_dsmdc_host_model.drop();
        end
        step(8'hff);
        chk(array_addr, a[14:8]);
        chk(row_strobe, 8'h01 << b);
        chk(byte_write_en, e);
        chk({write_dir_flag, array_out_latch_en}, {!c1, c1});
        step(8'hef);
        if (c1) begin
            i_dsmdc_host_model.wack(ok);
            chk({ok, out_en}, 2'h3);
            i_dsmdc_host_model.drop();
        end
        step(8'h00);
        chk({slave_ack_int, out_en, array_out_latch_en, row_strobe}, 11'h000);
    endtask
    task refr(input logic [6:0] v);
        @(negedge sys_clk);
        rf = 1'h1;
        ra = v;
        step(8'h80);
        chk(array_addr, v);
        step(8'h84);
        chk(row_strobe, 8'hff);
        chk({byte_write_en, slave_ack_int, refresh_ind}, 4'h1);
        step(8'h00);
        @(negedge sys_clk);
        rf = 1'h0;
    endtask
    task creg(input logic c1, input logic x);
        @(negedge sys_clk);
        ext = x;
        g = c1 ? {2'h3, !x, x, 1'h0} : 5'h01;
        i_dsmdc_host_model.req(c1, 1'h1, 1'h1, a, 3'h0);
        i_dsmdc_host_model.wack(ok);
        chk(ok, 1'h1);
        chk({out_en, reg_common_out_en, reg_data_out_en, ext_err_addr_out_en, reg_write_clock}, g);
        chk({row_strobe, array_out_latch_en, refresh_ind}, 10'h000);
        i_dsmdc_host_model.drop();
        step(8'h00);
        chk({slave_ack_int, out_en, reg_write_clock}, 3'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, rf, ext, tp, ra, a} = 33'h0;
        repeat (8) @(posedge sys_clk);
        chk({row_strobe, slave_ack_int}, 9'h000);
        @(negedge sys_clk);
        rstn = 1'h1;
        // Every transfer type twice, across all eight banks
        for (int i = 0; i < 10; i++) begin
            k = i % 5;
            a = 15'h2b54 + 15'h0123 * 15'(i);
            a[0] = (k == 4);
            mem(k < 2, k == 0 || k == 2, 3'(i));
        end
        refr(7'h55);
        refr(7'h2a);
        creg(1'h1, 1'h0);
        creg(1'h1, 1'h1);
        creg(1'h0, 1'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
